// ===== rtl/hpp_pkg.sv
// Package for the host packet protocol block: link timing, packet codes, states.
// Assumes a single 10 MHz device clock shared by every module that imports it.
package hpp_pkg;
  // ----------------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BAUD = 115_200;
  localparam int unsigned BIT_CYC = (CLK_HZ + BAUD / 2) / BAUD;
  localparam int unsigned HALF_CYC = BIT_CYC / 2;
  localparam int unsigned DATA_BITS = 8;
  // ----------------------------------------------------------------------
  // Packet codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] TYPE_REQ = 8'h52;
  localparam logic [7:0] TYPE_CONFIRM = 8'h43;
  localparam logic [7:0] TYPE_INDICATION = 8'h69;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_BUSY = 8'h01;
  localparam logic [7:0] ST_BAD_OP = 8'h02;
  localparam logic [7:0] CONFIRM_LEN = 8'h01;
  localparam logic [7:0] SEQ_LEN = 8'h02;
  localparam logic [15:0] SEQ_RESET = 16'h0000;
  localparam logic [15:0] SEQ_STEP = 16'h0001;
  // Transmit byte slots of one packet
  localparam logic [2:0] SLOT_TYPE = 3'h0;
  localparam logic [2:0] SLOT_OP = 3'h1;
  localparam logic [2:0] SLOT_LEN = 3'h2;
  localparam logic [2:0] SLOT_D0 = 3'h3;
  localparam logic [2:0] SLOT_D1 = 3'h4;
  localparam logic [2:0] SLOT_D2 = 3'h5;
  localparam logic [2:0] SLOT_D3 = 3'h6;
  // Request decoded from the host
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
  } hpp_req_t;
  typedef enum logic [2:0] {
    RX_TYPE = 3'b001,
    RX_OP = 3'b010,
    RX_SKIP = 3'b100
  } hpp_rx_st_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_LOAD = 3'b010,
    TX_WAIT = 3'b100
  } hpp_tx_st_t;
endpackage : hpp_pkg

// ===== rtl/hpp_uart.sv
// Byte-serial transceiver, 8 data bits, no parity, one stop bit.
// Assumes rx_pin is asynchronous; it is synchronised here before any use.
`timescale 1ns/10ps
module hpp_uart
  import hpp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_start,
  output logic tx_busy
);
  localparam int unsigned CW = $clog2(BIT_CYC + 1);
  // ----------------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------------
  logic sync1_ff, sync2_ff;
  logic rx_act_ff, nxt_rx_act;
  logic [CW-1:0] rx_cnt_ff, nxt_rx_cnt;
  logic [3:0] rx_bit_ff, nxt_rx_bit;
  logic [7:0] rx_sh_ff, nxt_rx_sh;
  logic rx_v_ff, nxt_rx_v;
  // Two-stage synchroniser on the pin
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end else begin
      sync1_ff <= rx_pin;
      sync2_ff <= sync1_ff;
    end
  end
  // Mid-bit sampling; a false start is dropped at the half bit
  always_comb begin
    nxt_rx_act = rx_act_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_v = 1'b0;
    if (!rx_act_ff) begin
      if (!sync2_ff) begin
        nxt_rx_act = 1'b1;
        nxt_rx_cnt = CW'(HALF_CYC);
        nxt_rx_bit = 4'h0;
      end
    end else if (rx_cnt_ff != '0) begin
      nxt_rx_cnt = rx_cnt_ff - 1'b1;
    end else begin
      nxt_rx_cnt = CW'(BIT_CYC - 1);
      nxt_rx_bit = rx_bit_ff + 1'b1;
      if (rx_bit_ff == 4'h0) begin
        if (sync2_ff) nxt_rx_act = 1'b0;
      end else if (rx_bit_ff <= 4'(DATA_BITS)) begin
        nxt_rx_sh = {sync2_ff, rx_sh_ff[7:1]};
      end else begin
        nxt_rx_act = 1'b0;
        nxt_rx_v = sync2_ff; // Framing error drops the byte
      end
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_act_ff <= 1'b0;
      rx_cnt_ff <= '0;
      rx_bit_ff <= 4'h0;
      rx_sh_ff <= 8'h00;
      rx_v_ff <= 1'b0;
    end else begin
      rx_act_ff <= nxt_rx_act;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_bit_ff <= nxt_rx_bit;
      rx_sh_ff <= nxt_rx_sh;
      rx_v_ff <= nxt_rx_v;
    end
  end
  assign rx_data = rx_sh_ff;
  assign rx_valid = rx_v_ff;
  // ----------------------------------------------------------------------
  // Transmit side
  // ----------------------------------------------------------------------
  logic [9:0] tx_sh_ff, nxt_tx_sh;
  logic [3:0] tx_left_ff, nxt_tx_left;
  logic [CW-1:0] tx_cnt_ff, nxt_tx_cnt;
  // Frame is stop, data, start shifted out LSB first
  always_comb begin
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_left = tx_left_ff;
    nxt_tx_cnt = tx_cnt_ff;
    if (tx_left_ff == 4'h0) begin
      if (tx_start) begin
        nxt_tx_sh = {1'b1, tx_data, 1'b0};
        nxt_tx_left = 4'(DATA_BITS + 2);
        nxt_tx_cnt = CW'(BIT_CYC - 1);
      end
    end else if (tx_cnt_ff != '0) begin
      nxt_tx_cnt = tx_cnt_ff - 1'b1;
    end else begin
      nxt_tx_sh = {1'b1, tx_sh_ff[9:1]};
      nxt_tx_left = tx_left_ff - 1'b1;
      nxt_tx_cnt = CW'(BIT_CYC - 1);
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_sh_ff <= 10'h3ff;
      tx_left_ff <= 4'h0;
      tx_cnt_ff <= '0;
    end else begin
      tx_sh_ff <= nxt_tx_sh;
      tx_left_ff <= nxt_tx_left;
      tx_cnt_ff <= nxt_tx_cnt;
    end
  end
  assign tx_pin = tx_sh_ff[0];
  assign tx_busy = (tx_left_ff != 4'h0);
endmodule : hpp_uart

// ===== rtl/hpp_top.sv
// Device end of the host packet protocol: parses requests, sends confirms
// and streams indications over a byte-serial link.
// Assumes measurement logic on ref_clk supplies start/stop decode and data words.
`timescale 1ns/10ps
module hpp_top
  import hpp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire logic op_known,
  input wire logic op_is_start,
  input wire logic op_is_stop,
  input wire logic dev_busy,
  input wire logic [7:0] start_op,
  input wire logic data_valid,
  input wire logic [7:0] data_op,
  input wire logic [15:0] data_word,
  input wire logic event_valid,
  input wire logic [7:0] event_op,
  output logic data_ready,
  output logic [7:0] req_opcode,
  output logic req_strobe,
  output logic streaming
);
  // ----------------------------------------------------------------------
  // Transceiver
  // ----------------------------------------------------------------------
  logic [7:0] rx_byte;
  logic rx_v;
  logic [7:0] tx_byte;
  logic tx_go;
  logic tx_busy;
  logic tx_pin_w;
  hpp_uart u_uart (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .rx_pin(rx_pin),
    .tx_pin(tx_pin_w),
    .rx_data(rx_byte),
    .rx_valid(rx_v),
    .tx_data(tx_byte),
    .tx_start(tx_go),
    .tx_busy(tx_busy)
  );
  // ----------------------------------------------------------------------
  // Request parser
  // ----------------------------------------------------------------------
  hpp_rx_st_t rx_st_ff, nxt_rx_st;
  hpp_req_t req_ff, nxt_req;
  // Host packets carry only requests; any other type byte is dropped alone and the next byte is read as a type
  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_req = '{valid: 1'b0, opcode: req_ff.opcode};
    if (rx_v) begin
      unique case (rx_st_ff)
        RX_TYPE: begin
          if (rx_byte == TYPE_REQ) nxt_rx_st = RX_OP;
        end // Anything else dropped here
        RX_OP: begin
          nxt_req = '{valid: 1'b1, opcode: rx_byte}; // Short form done
          nxt_rx_st = RX_TYPE;
        end
        RX_SKIP: nxt_rx_st = RX_TYPE;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_st_ff <= RX_TYPE;
      req_ff <= '0;
    end else begin
      rx_st_ff <= nxt_rx_st;
      req_ff <= nxt_req;
    end
  end
  // ----------------------------------------------------------------------
  // Session and transmit scheduler
  // ----------------------------------------------------------------------
  hpp_tx_st_t tx_st_ff, nxt_tx_st;
  logic cfm_pend_ff, nxt_cfm_pend;
  logic [7:0] cfm_op_ff, nxt_cfm_op;
  logic [7:0] cfm_st_ff, nxt_cfm_st;
  logic stream_ff, nxt_stream;
  logic start_ok_ff, nxt_start_ok;
  logic [15:0] seq_ff, nxt_seq;
  logic [7:0] pk_type_ff, nxt_pk_type;
  logic [7:0] pk_op_ff, nxt_pk_op;
  logic [7:0] pk_len_ff, nxt_pk_len;
  logic [23:0] pk_data_ff, nxt_pk_data;
  logic [2:0] slot_ff, nxt_slot;
  logic [2:0] last_ff, nxt_last;
  logic ready_ff, nxt_ready;
  logic [7:0] reqop_ff, nxt_reqop;
  logic reqstb_ff, nxt_reqstb;
  logic tx_go_ff, nxt_tx_go;
  logic [7:0] tx_byte_ff, nxt_tx_byte;
  logic [7:0] slot_byte;
  // Byte for the current slot, in wire order
  always_comb begin
    unique case (slot_ff)
      SLOT_TYPE: slot_byte = pk_type_ff;
      SLOT_OP: slot_byte = pk_op_ff;
      SLOT_LEN: slot_byte = pk_len_ff;
      SLOT_D0: slot_byte = pk_data_ff[7:0];
      SLOT_D1: slot_byte = pk_data_ff[15:8];
      SLOT_D2: slot_byte = pk_data_ff[23:16];
      default: slot_byte = 8'h00;
    endcase
  end
  // Confirms win over indications so the host hears back promptly
  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_cfm_pend = cfm_pend_ff;
    nxt_cfm_op = cfm_op_ff;
    nxt_cfm_st = cfm_st_ff;
    nxt_stream = stream_ff;
    nxt_start_ok = start_ok_ff;
    nxt_seq = seq_ff;
    nxt_pk_type = pk_type_ff;
    nxt_pk_op = pk_op_ff;
    nxt_pk_len = pk_len_ff;
    nxt_pk_data = pk_data_ff;
    nxt_slot = slot_ff;
    nxt_last = last_ff;
    nxt_ready = 1'b0;
    nxt_reqop = reqop_ff;
    nxt_reqstb = 1'b0;
    nxt_tx_go = 1'b0;
    nxt_tx_byte = tx_byte_ff;
    // Each request queues one confirm; set beats a send starting in the same cycle
    if (req_ff.valid) begin
      nxt_cfm_pend = 1'b1;
      nxt_cfm_op = req_ff.opcode;
      nxt_reqop = req_ff.opcode;
      nxt_reqstb = 1'b1;
      nxt_start_ok = op_known && !dev_busy && op_is_start;
      if (!op_known) nxt_cfm_st = ST_BAD_OP;
      else if (dev_busy && !op_is_stop) nxt_cfm_st = ST_BUSY;
      else nxt_cfm_st = ST_OK;
      if (op_known && op_is_stop) nxt_stream = 1'b0;
    end
    unique case (tx_st_ff)
      TX_IDLE: begin
        if (cfm_pend_ff && !req_ff.valid) begin
          nxt_cfm_pend = 1'b0;
          nxt_pk_type = TYPE_CONFIRM;
          nxt_pk_op = cfm_op_ff;
          nxt_pk_len = CONFIRM_LEN;
          nxt_pk_data = {16'h0000, cfm_st_ff};
          nxt_last = SLOT_D0;
          nxt_slot = SLOT_TYPE;
          nxt_tx_st = TX_LOAD;
          if (start_ok_ff) begin
            nxt_stream = 1'b1; // Stream only after an OK confirm
            nxt_seq = SEQ_RESET;
            nxt_start_ok = 1'b0;
          end
        end else if (stream_ff && data_valid && !req_ff.valid) begin
          nxt_ready = 1'b1;
          nxt_pk_type = TYPE_INDICATION;
          nxt_pk_op = data_op;
          nxt_pk_len = SEQ_LEN + SEQ_LEN; // Sequence plus one data word
          nxt_pk_data = {8'h00, seq_ff[7:0], seq_ff[15:8]}; // High byte first
          nxt_last = SLOT_D3;
          nxt_slot = SLOT_TYPE;
          nxt_tx_st = TX_LOAD;
          nxt_seq = seq_ff + SEQ_STEP;
        end else if (stream_ff && event_valid && !req_ff.valid) begin
          nxt_pk_type = TYPE_INDICATION;
          nxt_pk_op = event_op;
          nxt_pk_len = 8'h00;
          nxt_pk_data = 24'h000000;
          nxt_last = SLOT_LEN;
          nxt_slot = SLOT_TYPE;
          nxt_tx_st = TX_LOAD;
        end
      end
      TX_LOAD: begin
        if (!tx_busy) begin
          nxt_tx_go = 1'b1;
          nxt_tx_byte = slot_byte;
          nxt_tx_st = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (!tx_go_ff && !tx_busy) begin
          if (slot_ff == last_ff) begin
            nxt_tx_st = TX_IDLE;
          end else begin
            nxt_slot = slot_ff + 1'b1;
            nxt_tx_st = TX_LOAD;
          end
        end
      end
    endcase
  end
  // Data word captured into the last two slots when accepted
  logic [7:0] d_lo_ff, nxt_d_lo;
  logic [7:0] d_hi_ff, nxt_d_hi;
  always_comb begin
    nxt_d_lo = d_lo_ff;
    nxt_d_hi = d_hi_ff;
    if (nxt_ready) begin
      nxt_d_hi = data_word[15:8];
      nxt_d_lo = data_word[7:0];
    end
  end
  assign tx_byte = (slot_ff == SLOT_D2 && pk_len_ff == SEQ_LEN + SEQ_LEN) ? d_hi_ff :
                   (slot_ff == SLOT_D3) ? d_lo_ff : tx_byte_ff;
  assign tx_go = tx_go_ff;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_st_ff <= TX_IDLE;
      cfm_pend_ff <= 1'b0;
      cfm_op_ff <= 8'h00;
      cfm_st_ff <= ST_OK;
      stream_ff <= 1'b0;
      start_ok_ff <= 1'b0;
      seq_ff <= SEQ_RESET;
      pk_type_ff <= 8'h00;
      pk_op_ff <= 8'h00;
      pk_len_ff <= 8'h00;
      pk_data_ff <= 24'h000000;
      slot_ff <= SLOT_TYPE;
      last_ff <= SLOT_TYPE;
      ready_ff <= 1'b0;
      reqop_ff <= 8'h00;
      reqstb_ff <= 1'b0;
      tx_go_ff <= 1'b0;
      tx_byte_ff <= 8'h00;
      d_lo_ff <= 8'h00;
      d_hi_ff <= 8'h00;
    end else begin
      tx_st_ff <= nxt_tx_st;
      cfm_pend_ff <= nxt_cfm_pend;
      cfm_op_ff <= nxt_cfm_op;
      cfm_st_ff <= nxt_cfm_st;
      stream_ff <= nxt_stream;
      start_ok_ff <= nxt_start_ok;
      seq_ff <= nxt_seq;
      pk_type_ff <= nxt_pk_type;
      pk_op_ff <= nxt_pk_op;
      pk_len_ff <= nxt_pk_len;
      pk_data_ff <= nxt_pk_data;
      slot_ff <= nxt_slot;
      last_ff <= nxt_last;
      ready_ff <= nxt_ready;
      reqop_ff <= nxt_reqop;
      reqstb_ff <= nxt_reqstb;
      tx_go_ff <= nxt_tx_go;
      tx_byte_ff <= nxt_tx_byte;
      d_lo_ff <= nxt_d_lo;
      d_hi_ff <= nxt_d_hi;
    end
  end
  // Registered pin; one extra cycle of latency on the line
  logic tx_pin_ff;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) tx_pin_ff <= 1'b1;
    else tx_pin_ff <= tx_pin_w;
  end
  assign tx_pin = tx_pin_ff;
  assign data_ready = ready_ff;
  assign req_opcode = reqop_ff;
  assign req_strobe = reqstb_ff;
  assign streaming = stream_ff;
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_confirm_follows;
    @(posedge ref_clk) disable iff (!resetn) req_ff.valid |=> cfm_pend_ff;
  endproperty
  a_confirm_follows: assert property (p_confirm_follows) else $error("no confirm queued");
  property p_stop_ends;
    @(posedge ref_clk) disable iff (!resetn)
      (req_ff.valid && op_known && op_is_stop) |=> !stream_ff;
  endproperty
  a_stop_ends: assert property (p_stop_ends) else $error("stream not stopped");
  property p_seq_step;
    @(posedge ref_clk) disable iff (!resetn)
      (ready_ff && $past(tx_st_ff) == TX_IDLE) |-> seq_ff == $past(seq_ff) + SEQ_STEP;
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("sequence not incremented");
  property p_bad_op;
    @(posedge ref_clk) disable iff (!resetn)
      (req_ff.valid && !op_known) |=> cfm_st_ff == ST_BAD_OP;
  endproperty
  a_bad_op: assert property (p_bad_op) else $error("bad opcode status wrong");
  property p_busy;
    @(posedge ref_clk) disable iff (!resetn)
      (req_ff.valid && op_known && dev_busy && !op_is_stop) |=> cfm_st_ff == ST_BUSY;
  endproperty
  a_busy: assert property (p_busy) else $error("busy status wrong");
  property p_req_type;
    @(posedge ref_clk) disable iff (!resetn)
      (rx_v && rx_st_ff == RX_TYPE && rx_byte != TYPE_REQ) |=> rx_st_ff == RX_TYPE;
  endproperty
  a_req_type: assert property (p_req_type) else $error("non-request not dropped");
  property p_short_req;
    @(posedge ref_clk) disable iff (!resetn)
      (rx_v && rx_st_ff == RX_OP) |=> (req_ff.valid && req_ff.opcode == $past(rx_byte));
  endproperty
  a_short_req: assert property (p_short_req) else $error("short request lost");
  property p_ind_needs_stream;
    @(posedge ref_clk) disable iff (!resetn)
      ($past(tx_st_ff) == TX_IDLE && tx_st_ff == TX_LOAD && pk_type_ff == TYPE_INDICATION)
        |-> $past(stream_ff);
  endproperty
  a_ind_needs_stream: assert property (p_ind_needs_stream) else $error("unsolicited indication");
  property p_first_type;
    @(posedge ref_clk) disable iff (!resetn)
      (tx_go_ff && slot_ff == SLOT_TYPE) |-> (tx_byte == TYPE_CONFIRM || tx_byte == TYPE_INDICATION);
  endproperty
  a_first_type: assert property (p_first_type) else $error("bad type byte");
endmodule : hpp_top

// ===== verif/hpp_host_model.sv
// Host model: sends request bytes to the device and collects its replies.
// Assumes the device clock; one bit lasts BIT_CYC cycles of ref_clk.
`timescale 1ns/10ps
module hpp_host_model
  import hpp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic dev_tx,
  output logic host_tx
);
  // ----------------------------------------------------------------------
  // Transmit side
  // ----------------------------------------------------------------------
  logic [7:0] rxq[$];
  logic [7:0] sh;
  // Idle line rests high between frames
  initial host_tx = 1'b1;
  // One frame: start, eight data bits LSB first, one stop, no parity
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      #5 host_tx = fr[i];
      repeat (BIT_CYC - 1) @(posedge ref_clk);
    end
  endtask : send_byte
  // Only the host opens an exchange, short two-byte form
  task automatic send_request(input logic [7:0] op);
    send_byte(TYPE_REQ);
    send_byte(op);
  endtask : send_request
  // ----------------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------------
  // Always listening, so streamed data after a confirm is kept
  initial begin
    forever begin
      @(negedge dev_tx);
      repeat (HALF_CYC) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge ref_clk);
        sh[i] = dev_tx;
      end
      repeat (BIT_CYC) @(posedge ref_clk);
      // Bad stop bit queues an unknown so the next compare fails
      rxq.push_back(dev_tx === 1'b1 ? sh : 8'hxx);
    end
  end
endmodule : hpp_host_model

// ===== verif/hpp_top_bench.sv
// Self-checking bench for the device end of the host packet protocol.
// Assumes hpp_host_model stands on the serial pins; user side driven here.
`timescale 1ns/10ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR t=%0t: got %h expected %h", $time, got, exp); end end
module hpp_top_bench;
  import hpp_pkg::*;
  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  logic ref_clk, resetn, rx_pin, tx_pin, op_known, op_is_start, op_is_stop, dev_busy;
  logic [7:0] start_op, data_op, event_op, req_opcode;
  logic data_valid, event_valid, data_ready, req_strobe, streaming;
  logic [15:0] data_word;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int n_strobe = 0;
  hpp_top dut (.ref_clk(ref_clk), .resetn(resetn), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .op_known(op_known), .op_is_start(op_is_start), .op_is_stop(op_is_stop),
    .dev_busy(dev_busy), .start_op(start_op), .data_valid(data_valid),
    .data_op(data_op), .data_word(data_word), .event_valid(event_valid),
    .event_op(event_op), .data_ready(data_ready), .req_opcode(req_opcode),
    .req_strobe(req_strobe), .streaming(streaming));
  hpp_host_model host (.ref_clk(ref_clk), .dev_tx(tx_pin), .host_tx(rx_pin));
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Request strobes seen, one per two-byte request, rejected ones included
  always @(posedge ref_clk) begin
    if (req_strobe === 1'b1) n_strobe++;
  end
  // Ceiling well above the roughly 45k cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      $display("ERROR t=%0t: run timed out", $time);
      conclude();
    end
  end
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic conclude();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  // Bounded wait for one byte from the device
  task automatic get_byte(output logic [7:0] b);
    int t;
    t = 0;
    while (host.rxq.size() == 0 && t < 20000) begin
      @(posedge ref_clk);
      t++;
    end
    b = (host.rxq.size() == 0) ? 8'hxx : host.rxq.pop_front();
  endtask : get_byte
  task automatic expect_pkt(input logic [7:0] e[]);
    logic [7:0] b;
    foreach (e[i]) begin
      get_byte(b);
      `CHK(b, e[i])
    end
  endtask : expect_pkt
  // User decode is set up before the opcode reaches the device
  task automatic request(input logic [7:0] op, input logic known, input logic busy);
    @(posedge ref_clk);
    #5;
    op_known = known;
    op_is_start = (op == 8'h12);
    op_is_stop = (op == 8'h13);
    dev_busy = busy;
    host.send_request(op);
  endtask : request
  // Hold a data word until the device takes it
  task automatic send_word(input logic [15:0] w);
    int t;
    t = 0;
    @(posedge ref_clk);
    #5;
    data_valid = 1'b1;
    data_word = w;
    do begin
      @(posedge ref_clk);
      #1;
      t++;
    end while (data_ready !== 1'b1 && t < 20000);
    #4 data_valid = 1'b0;
    `CHK(data_ready, 1'b1)
  endtask : send_word
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Stray byte first; parser must skip it and still take the request
  task automatic t_resync();
    host.send_byte(8'ha5);
    request(8'h29, 1'b1, 1'b0);
    expect_pkt('{TYPE_CONFIRM, 8'h29, 8'h01, 8'h00});
    `CHK(req_opcode, 8'h29)
    $display("test resync done");
  endtask : t_resync
  task automatic t_unknown_and_busy();
    request(8'h77, 1'b0, 1'b0);
    expect_pkt('{TYPE_CONFIRM, 8'h77, 8'h01, 8'h02});
    request(8'h12, 1'b1, 1'b1);
    expect_pkt('{TYPE_CONFIRM, 8'h12, 8'h01, 8'h01});
    `CHK(streaming, 1'b0)
    $display("test unknown and busy done");
  endtask : t_unknown_and_busy
  // Accepted start, then two data words and one event
  task automatic t_stream();
    request(8'h12, 1'b1, 1'b0);
    expect_pkt('{TYPE_CONFIRM, 8'h12, 8'h01, 8'h00});
    `CHK(streaming, 1'b1)
    send_word(16'hbeef);
    expect_pkt('{TYPE_INDICATION, 8'h14, 8'h04, 8'h00, 8'h00, 8'hbe, 8'hef});
    send_word(16'h0102);
    expect_pkt('{TYPE_INDICATION, 8'h14, 8'h04, 8'h00, 8'h01, 8'h01, 8'h02});
    @(posedge ref_clk);
    #5 event_valid = 1'b1;
    expect_pkt('{TYPE_INDICATION, 8'h03, 8'h00});
    @(posedge ref_clk);
    #5 event_valid = 1'b0;
    $display("test stream done");
  endtask : t_stream
  // Stop request ends the stream; later data must not go out
  task automatic t_stop();
    request(8'h13, 1'b1, 1'b0);
    expect_pkt('{TYPE_CONFIRM, 8'h13, 8'h01, 8'h00});
    `CHK(streaming, 1'b0)
    @(posedge ref_clk);
    #5;
    data_valid = 1'b1;
    data_word = 16'h5555;
    repeat (3000) @(posedge ref_clk);
    #5 data_valid = 1'b0;
    `CHK(host.rxq.size(), 0)
    $display("test stop done");
  endtask : t_stop
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    op_known = 1'b0;
    op_is_start = 1'b0;
    op_is_stop = 1'b0;
    dev_busy = 1'b0;
    start_op = 8'h12;
    data_valid = 1'b0;
    data_op = 8'h14;
    data_word = 16'h0000;
    event_valid = 1'b0;
    event_op = 8'h03;
    repeat (4) @(posedge ref_clk);
    #5 resetn = 1'b1;
    `CHK(tx_pin, 1'b1)
    t_resync();
    t_unknown_and_busy();
    t_stream();
    t_stop();
    `CHK(n_strobe, 5)
    conclude();
  end
endmodule : hpp_top_bench
